// *** shared/sffs_pkg.sv ***
// Constants, register map and state codes of the sensor fault flag supervisor.
// Assumes one 200 MHz clock; every time below is turned into a cycle count here.
package sffs_pkg;

  // ==========================================================================
  // Clock and time conversion
  localparam int CLK_MHZ = 200;

  // Least times round up to whole cycles.
  function automatic int cyc_up(input longint ns);
    return int'((ns * CLK_MHZ + 999) / 1000);
  endfunction : cyc_up

  // ==========================================================================
  // Times in nanoseconds
  localparam int T_PROBE_LOW_NS = 32000;
  localparam int T_SHORT_PULSE_NS = 280;
  localparam int T_SHORT_LONG_NS = 25000;
  localparam int T_HOLD_NS = 3300000;
  localparam int T_STARTUP_NS = 42000;
  localparam int T_DG_ON_NS = 25600;
  localparam int T_DG_OFF_NS = 25000;
  localparam int T_DEGAUSS_NS = 110000000;
  localparam int T_SUPPLY_NS = 100000;
  localparam int T_COIL_NS = 100000;

  // ==========================================================================
  // Cycle counts
  localparam int PROBE_LOW_CYC = cyc_up(T_PROBE_LOW_NS);
  localparam int SHORT_PULSE_CYC = cyc_up(T_SHORT_PULSE_NS);
  localparam int SHORT_LONG_CYC = cyc_up(T_SHORT_LONG_NS);
  localparam int HOLD_CYC = cyc_up(T_HOLD_NS);
  localparam int STARTUP_CYC = cyc_up(T_STARTUP_NS);
  localparam int DG_ON_CYC = cyc_up(T_DG_ON_NS);
  localparam int DG_OFF_CYC = cyc_up(T_DG_OFF_NS);
  localparam int DEGAUSS_CYC = cyc_up(T_DEGAUSS_NS);
  localparam int SUPPLY_CYC = cyc_up(T_SUPPLY_NS);
  localparam int COIL_CYC = cyc_up(T_COIL_NS);
  localparam logic [1:0] SHORT_RUNS = 2'h3;
  localparam logic [2:0] GOOD_CYCLES = 3'h4;

  // ==========================================================================
  // Widths
  localparam int TIMER_W = 25;
  localparam int HALF_W = 13;
  localparam int FILT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EV_W = 6;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam int CTRL_DG_BIT = 0;
  localparam int CTRL_COIL_BIT = 1;
  localparam logic CTRL_COIL_RESET = 1'h1;
  localparam logic [5:0] IRQ_EN_RESET = 6'h00;
  localparam int EV_PROBE = 0;
  localparam int EV_SHORT = 1;
  localparam int EV_COIL = 2;
  localparam int EV_SUPPLY = 3;
  localparam int EV_DG_END = 4;
  localparam int EV_READY = 5;

  // ==========================================================================
  // Supervisor states
  typedef enum logic [2:0] {
    ST_STARTUP = 3'b000,
    ST_DEGAUSS = 3'b001,
    ST_RUN = 3'b010,
    ST_SHORT = 3'b011,
    ST_PROBE_FAULT = 3'b100,
    ST_HOLD = 3'b101
  } sffs_state_e;

endpackage : sffs_pkg

// *** hdl/sffs_filt.sv ***
// Pin qualifier: two-flop synchroniser, then a level that only follows the pin
// after it has held its new value for HI_CYC (rising) or LO_CYC (falling) cycles.
`timescale 1ns/1ps
module sffs_filt #(
  parameter int HI_CYC = 1,
  parameter int LO_CYC = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pin and qualified level
  input wire logic pin,
  output logic q
);
  import sffs_pkg::*;

  logic s1_r, s2_r, q_r, q_nxt;
  logic [FILT_W-1:0] cnt_r, cnt_nxt;

  // ==========================================================================
  // Qualification
  always_comb begin
    cnt_nxt = '0;
    q_nxt = q_r;
    if (s2_r != q_r) begin
      if (cnt_r >= (q_r ? FILT_W'(LO_CYC - 1) : FILT_W'(HI_CYC - 1))) begin
        q_nxt = s2_r;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      q_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      q_r <= q_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign q = q_r;

endmodule : sffs_filt

// *** hdl/sffs_probe.sv ***
// Probe oscillation monitor: times each half-period of the comparator output.
// The comparator is asynchronous to pclk and is synchronised here.
`timescale 1ns/1ps
module sffs_probe #(
  parameter int LOW_CYC = 6400
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Probe comparator pin
  input wire logic probe_comparator,
  // Qualified probe conditions
  output logic probe_dead,
  output logic probe_short,
  output logic probe_good
);
  import sffs_pkg::*;

  logic s1_r, s2_r, s3_r, dead_r, dead_nxt, low_ok_r, low_ok_nxt;
  logic [HALF_W-1:0] len_r, len_nxt;
  logic [1:0] runs_r, runs_nxt;
  logic [2:0] good_r, good_nxt;
  logic half_ok;

  // ==========================================================================
  // Half-period measurement
  always_comb begin
    half_ok = (len_r >= HALF_W'(SHORT_PULSE_CYC)) && (len_r < HALF_W'(LOW_CYC));
    len_nxt = (len_r == '1) ? len_r : len_r + 1'b1;
    dead_nxt = dead_r;
    low_ok_nxt = low_ok_r;
    runs_nxt = runs_r;
    good_nxt = good_r;
    if (s2_r != s3_r) begin
      len_nxt = HALF_W'(1);
      if (s2_r) begin
        low_ok_nxt = half_ok;
        dead_nxt = 1'b0;
      end else begin
        if (len_r < HALF_W'(SHORT_PULSE_CYC)) begin
          runs_nxt = (runs_r == SHORT_RUNS) ? runs_r : runs_r + 1'b1;
        end else begin
          runs_nxt = '0;
        end
        if (low_ok_r && half_ok) begin
          good_nxt = (good_r == GOOD_CYCLES) ? good_r : good_r + 1'b1;
        end else begin
          good_nxt = '0;
        end
      end
    end else if (!s2_r && len_r >= HALF_W'(LOW_CYC)) begin
      dead_nxt = 1'b1;
      good_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      len_r <= '0;
      dead_r <= 1'b0;
      low_ok_r <= 1'b0;
      runs_r <= '0;
      good_r <= '0;
    end else begin
      s1_r <= probe_comparator;
      s2_r <= s1_r;
      s3_r <= s2_r;
      len_r <= len_nxt;
      dead_r <= dead_nxt;
      low_ok_r <= low_ok_nxt;
      runs_r <= runs_nxt;
      good_r <= good_nxt;
    end
  end

  assign probe_dead = dead_r;
  assign probe_short = (runs_r == SHORT_RUNS);
  assign probe_good = (good_r == GOOD_CYCLES);

endmodule : sffs_probe

// *** hdl/sffs_top.sv ***
// Sensor fault flag supervisor: drives the open-drain fault and clip flags and
// the compensation driver enable from probe, coil, supply and degauss inputs.
// Assumes asynchronous pins, an APB master on pclk and external pull-ups.
//
// Function
// - Probe low over 32 us raises fault.
// - Driver stays on while counting, off after.
// - Probe recovery: flag and driver reset 3.3 ms.
// - Three short probe pulses raise fault.
// - Short over 25 us then clear: 3.3 ms hold.
// - Short cleared within 25 us: release immediately.
// - Degauss abort: flag low, driver off 3.3 ms.
// - Open coil over 100 us: flag only.
// - Coil check enable low suppresses coil detection.
// - After power-on flag low about 42 us.
// - Supply low over 100 us: restart power-up.
// - Flag low throughout every degauss cycle.
// - Release flag once normal operation resumes.
// - Flags are open-drain, pull low only.
// - Degauss request needs 25.6 us high.
// - Degauss cycle lasts about 110 ms.
// - Abort needs request low 25 us.
// - Start needs four good probe cycles.
`timescale 1ns/1ps
module sffs_top #(
  parameter int PROBE_LOW_P = sffs_pkg::PROBE_LOW_CYC,
  parameter int SHORT_LONG_P = sffs_pkg::SHORT_LONG_CYC,
  parameter int HOLD_P = sffs_pkg::HOLD_CYC,
  parameter int STARTUP_P = sffs_pkg::STARTUP_CYC,
  parameter int DG_ON_P = sffs_pkg::DG_ON_CYC,
  parameter int DG_OFF_P = sffs_pkg::DG_OFF_CYC,
  parameter int DEGAUSS_P = sffs_pkg::DEGAUSS_CYC,
  parameter int SUPPLY_P = sffs_pkg::SUPPLY_CYC,
  parameter int COIL_P = sffs_pkg::COIL_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sffs_pkg::ADDR_W-1:0] paddr,
  input wire logic [sffs_pkg::DATA_W-1:0] pwdata,
  output logic [sffs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous sensor and controller pins
  input wire logic probe_comparator,
  input wire logic coil_current_low,
  input wire logic coil_check_enable,
  input wire logic supply_low,
  input wire logic degauss_request,
  input wire logic clip_detect,
  // Open-drain flags
  output logic fault_flag_out,
  output logic fault_flag_oe_n,
  output logic clip_flag_out,
  output logic clip_flag_oe_n,
  // Driver control and interrupt
  output logic compensation_driver_en,
  output logic degauss_active,
  output logic irq
);
  import sffs_pkg::*;

  sffs_state_e state_r, state_nxt;
  logic [TIMER_W-1:0] timer_r, timer_nxt;
  logic pu_r, pu_nxt, probe_dead, probe_short, probe_good;
  logic dg_q, sup_q, coil_q, chk_q, clip_q;
  logic dg_prev_r, coil_prev_r, sup_prev_r, sw_dg_r, sw_dg_nxt;
  logic dg_rise, dg_fall, dg_start, coil_fault, timer_sat;
  logic [EV_W-1:0] ev, sts_r, sts_nxt, en_r, en_nxt;
  logic [DATA_W-1:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt, irq_r, irq_nxt, ctrl_coil_r, ctrl_coil_nxt;
  logic fault_oe_n_r, fault_oe_n_nxt, clip_oe_n_r, drv_en_r, drv_en_nxt, dg_act_r;
  logic pin_low_r, presetn_q_r, setup, acc_wr;

  // ==========================================================================
  // Pin qualification
  sffs_probe #(.LOW_CYC(PROBE_LOW_P)) u_probe (
    .pclk(pclk),
    .presetn(presetn),
    .probe_comparator(probe_comparator),
    .probe_dead(probe_dead),
    .probe_short(probe_short),
    .probe_good(probe_good)
  );

  // Request high filter and abort filter differ on purpose.
  sffs_filt #(.HI_CYC(DG_ON_P), .LO_CYC(DG_OFF_P)) u_dg (
    .pclk(pclk), .presetn(presetn), .pin(degauss_request), .q(dg_q)
  );
  sffs_filt #(.HI_CYC(SUPPLY_P), .LO_CYC(1)) u_sup (
    .pclk(pclk), .presetn(presetn), .pin(supply_low), .q(sup_q)
  );
  sffs_filt #(.HI_CYC(COIL_P), .LO_CYC(1)) u_coil (
    .pclk(pclk), .presetn(presetn), .pin(coil_current_low), .q(coil_q)
  );
  sffs_filt #(.HI_CYC(1), .LO_CYC(1)) u_chk (
    .pclk(pclk), .presetn(presetn), .pin(coil_check_enable), .q(chk_q)
  );
  sffs_filt #(.HI_CYC(1), .LO_CYC(1)) u_clip (
    .pclk(pclk), .presetn(presetn), .pin(clip_detect), .q(clip_q)
  );

  assign dg_rise = dg_q && !dg_prev_r;
  assign dg_fall = !dg_q && dg_prev_r;
  assign dg_start = dg_rise || sw_dg_r;
  assign coil_fault = coil_q && chk_q && ctrl_coil_r;
  assign timer_sat = (timer_r == '1);

  // ==========================================================================
  // Supervisor state machine
  always_comb begin
    state_nxt = state_r;
    pu_nxt = pu_r;
    case (state_r)
      ST_STARTUP: begin
        if ((pu_r && dg_q) || dg_start) begin
          state_nxt = ST_DEGAUSS;
        end else if (timer_r >= TIMER_W'(STARTUP_P - 1) && probe_good) begin
          state_nxt = ST_RUN;
        end
      end
      ST_DEGAUSS: begin
        if (dg_fall) begin
          state_nxt = ST_HOLD;
        end else if (timer_r >= TIMER_W'(DEGAUSS_P - 1)) begin
          state_nxt = ST_STARTUP;
        end
      end
      ST_RUN: begin
        if (probe_dead) begin
          state_nxt = ST_PROBE_FAULT;
        end else if (probe_short) begin
          state_nxt = ST_SHORT;
        end else if (dg_start) begin
          state_nxt = ST_DEGAUSS;
        end
      end
      ST_SHORT: begin
        if (probe_dead) begin
          state_nxt = ST_PROBE_FAULT;
        end else if (!probe_short) begin
          state_nxt = ST_RUN;
        end else if (timer_r >= TIMER_W'(SHORT_LONG_P - 1)) begin
          state_nxt = ST_PROBE_FAULT;
        end
      end
      ST_PROBE_FAULT: begin
        if (!probe_dead && !probe_short) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (probe_dead) begin
          state_nxt = ST_PROBE_FAULT;
        end else if (probe_short) begin
          state_nxt = ST_SHORT;
        end else if (timer_r >= TIMER_W'(HOLD_P - 1)) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_STARTUP;
    endcase
    if (sup_q) begin
      state_nxt = ST_STARTUP;
      pu_nxt = 1'b1;
    end else if (state_nxt != ST_STARTUP) begin
      pu_nxt = 1'b0;
    end
    // Each new state restarts the shared timer; a finished degauss skips the wait.
    if (sup_q || state_nxt != state_r) begin
      timer_nxt = '0;
    end else begin
      timer_nxt = timer_sat ? timer_r : timer_r + 1'b1;
    end
    if (!sup_q && state_r == ST_DEGAUSS && state_nxt == ST_STARTUP) begin
      timer_nxt = TIMER_W'(STARTUP_P - 1);
    end
    // Outputs follow the next state so they change with it, not a cycle later.
    fault_oe_n_nxt = (state_nxt == ST_RUN) && !coil_fault && !sup_q;
    drv_en_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_SHORT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_STARTUP;
      timer_r <= '0;
      pu_r <= 1'b1;
      dg_prev_r <= 1'b0;
      coil_prev_r <= 1'b0;
      sup_prev_r <= 1'b0;
      fault_oe_n_r <= 1'b0;
      clip_oe_n_r <= 1'b1;
      drv_en_r <= 1'b0;
      dg_act_r <= 1'b0;
      pin_low_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      pu_r <= pu_nxt;
      dg_prev_r <= dg_q;
      coil_prev_r <= coil_fault;
      sup_prev_r <= sup_q;
      fault_oe_n_r <= fault_oe_n_nxt;
      clip_oe_n_r <= !clip_q;
      drv_en_r <= drv_en_nxt;
      dg_act_r <= (state_nxt == ST_DEGAUSS);
      pin_low_r <= 1'b0;
    end
  end

  // ==========================================================================
  // APB registers and interrupt
  always_comb begin
    setup = psel && !penable;
    acc_wr = psel && penable && pwrite;
    ev = '0;
    ev[EV_PROBE] = (state_nxt == ST_PROBE_FAULT) && (state_r != ST_PROBE_FAULT);
    ev[EV_SHORT] = (state_nxt == ST_SHORT) && (state_r != ST_SHORT);
    ev[EV_COIL] = coil_fault && !coil_prev_r;
    ev[EV_SUPPLY] = sup_q && !sup_prev_r;
    ev[EV_DG_END] = (state_r == ST_DEGAUSS) && (state_nxt != ST_DEGAUSS);
    ev[EV_READY] = (state_nxt == ST_RUN) && (state_r != ST_RUN);
    ctrl_coil_nxt = ctrl_coil_r;
    sw_dg_nxt = 1'b0;
    en_nxt = en_r;
    sts_nxt = sts_r;
    if (acc_wr && paddr == ADDR_CTRL) begin
      ctrl_coil_nxt = pwdata[CTRL_COIL_BIT];
      sw_dg_nxt = pwdata[CTRL_DG_BIT];
    end
    if (acc_wr && paddr == ADDR_IRQ_EN) begin
      en_nxt = pwdata[EV_W-1:0];
    end
    if (acc_wr && paddr == ADDR_IRQ_CLR) begin
      sts_nxt = sts_r & ~pwdata[EV_W-1:0];
    end
    // A new event in the clearing cycle survives the clear.
    sts_nxt = sts_nxt | ev;
    irq_nxt = |(sts_nxt & en_nxt);
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      prdata_nxt = '0;
      pslverr_nxt = 1'b0;
      case (paddr)
        ADDR_CTRL: prdata_nxt = DATA_W'({ctrl_coil_r, 1'b0});
        ADDR_STATUS: prdata_nxt = DATA_W'({dg_q, sup_q, coil_fault, probe_good, probe_short,
                                           probe_dead, drv_en_r, !fault_oe_n_r, state_r});
        ADDR_IRQ_STS: prdata_nxt = DATA_W'(sts_r);
        ADDR_IRQ_CLR: prdata_nxt = '0;
        ADDR_IRQ_EN: prdata_nxt = DATA_W'(en_r);
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_coil_r <= CTRL_COIL_RESET;
      sw_dg_r <= 1'b0;
      en_r <= IRQ_EN_RESET;
      sts_r <= '0;
      irq_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
      presetn_q_r <= 1'b0;
    end else begin
      ctrl_coil_r <= ctrl_coil_nxt;
      sw_dg_r <= sw_dg_nxt;
      en_r <= en_nxt;
      sts_r <= sts_nxt;
      irq_r <= irq_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      presetn_q_r <= 1'b1; // Zero-wait slave: ready from the first edge after reset.
    end
  end

  assign prdata = prdata_r;
  assign pready = presetn_q_r;
  assign pslverr = pslverr_r;
  assign fault_flag_out = pin_low_r;
  assign fault_flag_oe_n = fault_oe_n_r;
  assign clip_flag_out = pin_low_r;
  assign clip_flag_oe_n = clip_oe_n_r;
  assign compensation_driver_en = drv_en_r;
  assign degauss_active = dg_act_r;
  assign irq = irq_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  drv_off_a : assert property (
    state_r == ST_PROBE_FAULT |-> !compensation_driver_en && !fault_flag_oe_n)
    else $error("driver on or flag free during probe fault");
  hold_flag_a : assert property (
    state_r == ST_HOLD && timer_r < TIMER_W'(HOLD_P - 2) && !sup_q
      |=> !fault_flag_oe_n && !compensation_driver_en)
    else $error("hold released early");
  short_keep_a : assert property (
    state_r == ST_SHORT |-> compensation_driver_en ##0 !fault_flag_oe_n)
    else $error("short pulse interrupted driver or freed flag");
  short_long_a : assert property (
    state_r == ST_SHORT && probe_short && !sup_q
      && timer_r == TIMER_W'(SHORT_LONG_P - 1) |=> state_r == ST_PROBE_FAULT)
    else $error("long short condition not escalated");
  abort_a : assert property (
    state_r == ST_DEGAUSS && dg_fall && !sup_q |=> state_r == ST_HOLD ##1 !drv_en_r)
    else $error("degauss abort not followed by hold");
  dg_flag_a : assert property (
    degauss_active |-> !fault_flag_oe_n)
    else $error("flag free during degauss");
  coil_only_a : assert property (
    state_r == ST_RUN && coil_fault && !sup_q |=> !fault_flag_oe_n && drv_en_r)
    else $error("open coil handling wrong");
  coil_mask_a : assert property (
    state_r == ST_RUN && !chk_q && !sup_q && !probe_dead && !probe_short
      && !dg_start |=> fault_flag_oe_n)
    else $error("coil check not suppressed");
  brown_a : assert property (
    $rose(sup_q) |=> (state_r == ST_STARTUP && !fault_flag_oe_n) [*2])
    else $error("brown-out did not restart power-up");
  irq_a : assert property (
    $past(|(sts_r & en_r)) && !$past(acc_wr) |-> irq)
    else $error("interrupt missing for enabled status");

  run_c : cover property (state_r == ST_STARTUP ##1 state_r == ST_RUN);
  dg_end_c : cover property (state_r == ST_DEGAUSS ##1 state_r == ST_STARTUP);
  hold_c : cover property (state_r == ST_HOLD ##1 state_r == ST_RUN);
  esc_c : cover property (state_r == ST_SHORT ##1 state_r == ST_PROBE_FAULT);

endmodule : sffs_top

// *** test/sffs_probe_model.sv ***
// Far-side model: probe comparator oscillation and the pulled-up flag line.
// Assumes a 5 ns bench clock; all times are given in those cycles.
`timescale 1ns/1ps
module sffs_probe_model #(
  parameter int HALF_CYC = 60,
  parameter int SHORT_CYC = 20
) (
  // Mode: 0 good, 1 stuck low, 2 short pulses
  input wire logic [1:0] mode,
  // Open-drain flag drivers
  input wire logic fault_flag_out,
  input wire logic fault_flag_oe_n,
  input wire logic clip_flag_out,
  input wire logic clip_flag_oe_n,
  // Comparator and wired-OR flag line
  output logic probe_comparator,
  output logic flag_wire
);
  // ==========================================================================
  // Oscillator
  // Mode is read once per period, so a change never cuts a half-period short.
  initial begin
    probe_comparator = 1'b0;
    forever begin
      probe_comparator = (mode != 2'h1);
      #((mode == 2'h2 ? SHORT_CYC : HALF_CYC) * 5);
      probe_comparator = 1'b0;
      #(HALF_CYC * 5);
    end
  end

  // ==========================================================================
  // Pull-up: a released flag reads high, the two flags share one line.
  assign flag_wire = (fault_flag_oe_n ? 1'b1 : fault_flag_out) &
                     (clip_flag_oe_n ? 1'b1 : clip_flag_out);
endmodule : sffs_probe_model

// *** test/tb_sffs_top.sv ***
// Self-checking bench of the fault flag supervisor, shortened counts.
// Assumes the probe model drives the comparator and resolves the flag line.
`timescale 1ns/1ps
module tb_sffs_top;
  import sffs_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, m, e; logic er;} sffs_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, dg_active, drv_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic coil_low, coil_en, sup_low, dg_req, clip, ff_out, ff_oe_n, cf_out, cf_oe_n;
  logic probe, flag_wire, err, armed;
  logic dropped = 1'b0;
  logic [1:0] mode;
  int mismatches, checks;
  sffs_row_s rows [8] = '{
    '{1'b1, ADDR_IRQ_EN, 32'h3f, 32'h0, 32'h0, 1'b0},
    '{1'b0, ADDR_IRQ_EN, 32'h0, 32'h3f, 32'h3f, 1'b0},
    '{1'b0, ADDR_STATUS, 32'h0, 32'h1f, 32'h12, 1'b0},
    '{1'b0, ADDR_IRQ_CLR, 32'h0, 32'hffffffff, 32'h0, 1'b0},
    '{1'b1, ADDR_STATUS, 32'h7, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h14, 32'h0, 32'hffffffff, 32'h0, 1'b1},
    '{1'b0, ADDR_CTRL, 32'h0, 32'h3, 32'h2, 1'b0},
    '{1'b1, ADDR_IRQ_CLR, 32'h3f, 32'h0, 32'h0, 1'b0}};

  // Probe low, hold, degauss and the degauss request filters are shortened; the rest keep their values.
  sffs_top #(.PROBE_LOW_P(64), .HOLD_P(200), .DEGAUSS_P(500), .DG_ON_P(40),
    .DG_OFF_P(30)) i_sffs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .probe_comparator(probe), .coil_current_low(coil_low), .coil_check_enable(coil_en),
    .supply_low(sup_low), .degauss_request(dg_req), .clip_detect(clip),
    .fault_flag_out(ff_out), .fault_flag_oe_n(ff_oe_n), .clip_flag_out(cf_out),
    .clip_flag_oe_n(cf_oe_n), .compensation_driver_en(drv_en), .degauss_active(dg_active),
    .irq(irq));
  sffs_probe_model i_sffs_probe_model (.mode(mode), .fault_flag_out(ff_out),
    .fault_flag_oe_n(ff_oe_n), .clip_flag_out(cf_out), .clip_flag_oe_n(cf_oe_n),
    .probe_comparator(probe), .flag_wire(flag_wire));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // A driver drop while armed means the driver was interrupted.
  always @(posedge pclk) if (armed && drv_en !== 1'b1) dropped <= 1'b1;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask : step

  task automatic wait_flag(input logic v, input int lim);
    int n;
    n = 0;
    while (ff_oe_n !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(ff_oe_n, v);
    if (n >= lim) end_of_test();
  endtask : wait_flag

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask : apb

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, coil_low, sup_low, dg_req, clip} = '0;
    {presetn, mode, armed, mismatches, checks} = '0;
    coil_en = 1'b1;
    step(4);
    chk({ff_oe_n, drv_en, pready}, 3'h0);
    presetn <= 1'b1;
    step(8300);
    chk(ff_oe_n, 1'b0);
    wait_flag(1'b1, 300);
    chk(drv_en, 1'b1);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd & rows[i].m, rows[i].e);
      chk(err, rows[i].er);
    end
    step(1);
    chk(irq, 1'b0);
    $display("test registers done");
    mode <= 2'h1;
    step(30);
    chk(drv_en, 1'b1);
    wait_flag(1'b0, 200);
    step(3);
    chk({drv_en, irq}, 2'h1);
    mode <= 2'h0;
    step(100);
    chk({ff_oe_n, drv_en}, 2'h0);
    wait_flag(1'b1, 3000);
    $display("test probe low done");
    armed <= 1'b1;
    mode <= 2'h2;
    wait_flag(1'b0, 400);
    mode <= 2'h0;
    wait_flag(1'b1, 300);
    chk(dropped, 1'b0);
    armed <= 1'b0;
    mode <= 2'h2;
    wait_flag(1'b0, 400);
    step(5100);
    mode <= 2'h0;
    step(150);
    chk({ff_oe_n, drv_en}, 2'h0);
    wait_flag(1'b1, 3000);
    $display("test short pulse done");
    coil_en <= 1'b0;
    coil_low <= 1'b1;
    step(20100);
    chk(ff_oe_n, 1'b1);
    coil_en <= 1'b1;
    wait_flag(1'b0, 100);
    chk(drv_en, 1'b1);
    coil_low <= 1'b0;
    wait_flag(1'b1, 100);
    $display("test coil done");
    dg_req <= 1'b1;
    step(20);
    dg_req <= 1'b0;
    step(60);
    chk(dg_active, 1'b0);
    dg_req <= 1'b1;
    step(60);
    chk({dg_active, ff_oe_n, flag_wire}, 3'h4);
    dg_req <= 1'b0;
    step(50);
    chk({dg_active, drv_en, ff_oe_n}, 3'h0);
    wait_flag(1'b1, 3000);
    apb(1'b1, ADDR_CTRL, 32'h3);
    step(400);
    chk({dg_active, ff_oe_n}, 2'h2);
    wait_flag(1'b1, 300);
    chk(dg_active, 1'b0);
    $display("test degauss done");
    sup_low <= 1'b1;
    step(19900);
    chk(ff_oe_n, 1'b1);
    step(200);
    chk({ff_oe_n, drv_en}, 2'h0);
    sup_low <= 1'b0;
    wait_flag(1'b1, 9000);
    clip <= 1'b1;
    step(6);
    chk(flag_wire, 1'b0);
    clip <= 1'b0;
    $display("test supply and clip done");
    end_of_test();
  end
endmodule : tb_sffs_top
